/* diag_record_pkg.sv */
package diag_record_pkg;

	// Clock and microsecond ticker timing
	localparam int unsigned CLK_PERIOD_NS = 100;
	localparam int unsigned TICK_PERIOD_NS = 1000;
	localparam int unsigned CYCLES_PER_TICK = TICK_PERIOD_NS / CLK_PERIOD_NS;
	localparam int unsigned PRESCALE_W = 4;
	localparam logic [PRESCALE_W-1:0] PRESCALE_LAST = PRESCALE_W'(CYCLES_PER_TICK - 1);
	localparam int unsigned TICKER_W = 32;
	localparam logic [TICKER_W-1:0] TICKER_RESET = 32'h0000_0000;

	// Parameter byte values
	localparam logic [7:0] DIAG_INT_DISABLE = 8'h00;
	localparam logic [7:0] DIAG_INT_ENABLE = 8'h40;
	localparam logic [7:0] DIAG_INT_ENABLE_RESET = 8'h00;

	// Access paths
	typedef enum logic [1:0] {
		PATH_RECORD_SET,
		PATH_OBJECT_INDEX,
		PATH_SUBINDEX,
		PATH_UNUSED
	} access_path_t;

	// Record set numbers
	localparam logic [15:0] DS_PARAM = 16'h0000;
	localparam logic [15:0] DS_DIAG_SHORT = 16'h0000;
	localparam logic [15:0] DS_DIAG_FULL = 16'h0001;
	// Object indices
	localparam logic [15:0] IX_PARAM = 16'h3100;
	localparam logic [15:0] IX_DIAG_SHORT = 16'h2F00;
	localparam logic [15:0] IX_DIAG_FULL = 16'h2F01;
	// Subindex object and entries
	localparam logic [15:0] SX_PARAM_INDEX = 16'h3100;
	localparam logic [7:0] SX_PARAM_SUB = 8'h01;
	localparam logic [15:0] SX_DIAG_INDEX = 16'h5005;
	localparam logic [7:0] SX_FIRST_BYTE = 8'h02;
	localparam logic [7:0] SX_LAST_BYTE = 8'h11;
	localparam logic [7:0] SX_TIMESTAMP = 8'h13;

	// Record layout
	localparam logic [4:0] REC_LEN_FULL = 5'd20;
	localparam logic [4:0] REC_LEN_SHORT = 5'd4;
	localparam logic [4:0] POS_ERROR_SUMMARY = 5'd0;
	localparam logic [4:0] POS_MODULE_CLASS = 5'd1;
	localparam logic [4:0] POS_CHANNEL_KIND = 5'd4;
	localparam logic [4:0] POS_TIMESTAMP = 5'd16;
	localparam logic [2:0] TIMESTAMP_BYTES = 3'd4;

	// Error summary bit positions
	localparam int unsigned ERR_MODULE_FAILURE = 0;
	localparam int unsigned ERR_INTERNAL = 1;
	localparam int unsigned ERR_EXTERNAL = 2;
	localparam int unsigned ERR_OVERLOAD = 4;
	localparam int unsigned ERR_PARAMETER = 7;
	localparam logic [7:0] ERROR_SUMMARY_RESET = 8'h00;

	// Fixed record contents
	localparam logic [3:0] MODULE_CLASS_DIGITAL = 4'hF;
	localparam logic [6:0] CHANNEL_KIND_DIGITAL_OUT = 7'h72;
	localparam logic [7:0] MODULE_CLASS_INFO_VALUE = {4'h1, MODULE_CLASS_DIGITAL};
	localparam logic [7:0] CHANNEL_KIND_VALUE = {1'b0, CHANNEL_KIND_DIGITAL_OUT};
	localparam logic [7:0] RESERVED_BYTE = 8'h00;

	localparam int unsigned OUTPUT_CHANNELS = 16;

endpackage

/* usec_ticker.sv */
`timescale 1ns/100ps
module usec_ticker (
	input wire logic mclk_in,
	input wire logic reset_n_in,
	output logic [diag_record_pkg::TICKER_W-1:0] usec_count_out
);

	logic [diag_record_pkg::PRESCALE_W-1:0] prescale_q;

	// Divides the clock down to one microsecond per count
	always_ff @(posedge mclk_in) begin
		if (!reset_n_in) begin
			prescale_q <= '0;
		end else if (prescale_q == diag_record_pkg::PRESCALE_LAST) begin
			prescale_q <= '0;
		end else begin
			prescale_q <= prescale_q + 1'b1;
		end
	end

	// Starts at zero and wraps after the maximum count
	always_ff @(posedge mclk_in) begin
		if (!reset_n_in) begin
			usec_count_out <= diag_record_pkg::TICKER_RESET;
		end else if (prescale_q == diag_record_pkg::PRESCALE_LAST) begin
			usec_count_out <= usec_count_out + 1'b1;
		end
	end

endmodule // usec_ticker

/* output_module_diag_record.sv */
// What this block does
// - Enable byte 00h disables, 40h enables interrupts
// - Raise incoming interrupt when enabled cause appears
// - Issue going interrupt automatically when cause clears
// - Record set 01h full, 00h first four
// - Index 2F01h full, 2F00h first four
// - Index 5005h subindices 02h through 11h and 13h
// - Capture ticker into timestamp at event
// - Summary bit 0 on module failure
// - Summary bit 1 on internal error
// - Summary bit 2 on external error
// - Summary bit 4 on output overload
// - Summary bit 7 on bad parameters
// - Module class nibble 1111b, digital module
// - Channel type 72h, digital output
// - Microsecond timer starts at zero on power-up
// - Timer is 32 bits and wraps
// - Reserved record bytes read 00h
`timescale 1ns/100ps
module output_module_diag_record (
	input wire logic mclk_in,
	input wire logic reset_n_in,
	input wire logic module_failure_in,
	input wire logic internal_error_in,
	input wire logic external_error_in,
	input wire logic [diag_record_pkg::OUTPUT_CHANNELS-1:0] overload_in,
	input wire logic req_valid_in,
	input wire logic req_write_in,
	input wire logic [1:0] req_path_in,
	input wire logic [15:0] req_index_in,
	input wire logic [7:0] req_sub_in,
	input wire logic [4:0] req_byte_in,
	input wire logic [7:0] req_wdata_in,
	output logic rsp_valid_out,
	output logic rsp_error_out,
	output logic [7:0] rsp_data_out,
	output logic diag_enabled_out,
	output logic diag_incoming_out,
	output logic diag_going_out,
	output logic diag_active_out
);

	localparam int unsigned FAULT_W = diag_record_pkg::OUTPUT_CHANNELS + 3;

	typedef enum logic [1:0] {
		DIAG_QUIET,
		DIAG_RAISED
	} diag_state_t;

	// Result of decoding one access: kind and byte position
	typedef enum logic [1:0] {
		HIT_NONE,
		HIT_RECORD,
		HIT_PARAM
	} hit_kind_t;

	logic [FAULT_W-1:0] fault_meta_q;
	logic [FAULT_W-1:0] fault_sync_q;
	logic [7:0] diag_interrupt_enable_q;
	logic param_bad_q;
	logic [7:0] error_summary_q;
	logic [7:0] error_summary_d;
	logic [31:0] event_timestamp_q;
	logic [31:0] usec_now;
	diag_state_t state_q;
	logic enabled;
	logic cause_any;
	hit_kind_t hit_kind;
	logic [4:0] hit_pos;
	logic param_write;
	logic raise_now;
	logic fall_now;

	usec_ticker u_ticker (
		.mclk_in(mclk_in),
		.reset_n_in(reset_n_in),
		.usec_count_out(usec_now)
	);

	// Record limit for the selected access; zero means no record
	function automatic logic [4:0] record_limit(
		input logic [1:0] path,
		input logic [15:0] index,
		input logic write
	);
		logic [4:0] limit;
		limit = 5'd0;
		if (write) begin
			limit = 5'd0;
		end else if (path == 2'(diag_record_pkg::PATH_RECORD_SET)) begin
			if (index == diag_record_pkg::DS_DIAG_FULL) begin
				limit = diag_record_pkg::REC_LEN_FULL;
			end else if (index == diag_record_pkg::DS_DIAG_SHORT) begin
				limit = diag_record_pkg::REC_LEN_SHORT;
			end
		end else if (path == 2'(diag_record_pkg::PATH_OBJECT_INDEX)) begin
			if (index == diag_record_pkg::IX_DIAG_FULL) begin
				limit = diag_record_pkg::REC_LEN_FULL;
			end else if (index == diag_record_pkg::IX_DIAG_SHORT) begin
				limit = diag_record_pkg::REC_LEN_SHORT;
			end
		end
		return limit;
	endfunction

	// Parameter byte lookup on the record set, object index and subindex paths
	function automatic logic is_param(
		input logic [1:0] path,
		input logic [15:0] index,
		input logic [7:0] sub,
		input logic [4:0] byte_no,
		input logic write
	);
		logic hit;
		hit = 1'b0;
		if (byte_no != 5'd0) begin
			hit = 1'b0;
		end else if (path == 2'(diag_record_pkg::PATH_RECORD_SET)) begin
			// Record set 00h is the parameter on write only
			hit = write && (index == diag_record_pkg::DS_PARAM);
		end else if (path == 2'(diag_record_pkg::PATH_OBJECT_INDEX)) begin
			hit = (index == diag_record_pkg::IX_PARAM);
		end else if (path == 2'(diag_record_pkg::PATH_SUBINDEX)) begin
			hit = (index == diag_record_pkg::SX_PARAM_INDEX) &&
				(sub == diag_record_pkg::SX_PARAM_SUB);
		end
		return hit;
	endfunction

	// Only the disable and enable codes are legal
	function automatic logic param_value_ok(
		input logic [7:0] value
	);
		return value == diag_record_pkg::DIAG_INT_DISABLE ||
			value == diag_record_pkg::DIAG_INT_ENABLE;
	endfunction

	// Byte of the diagnostic record at a position
	function automatic logic [7:0] record_byte(
		input logic [4:0] pos,
		input logic [7:0] summary,
		input logic [31:0] stamp
	);
		logic [7:0] value;
		value = diag_record_pkg::RESERVED_BYTE;
		if (pos == diag_record_pkg::POS_ERROR_SUMMARY) begin
			value = summary;
		end else if (pos == diag_record_pkg::POS_MODULE_CLASS) begin
			value = diag_record_pkg::MODULE_CLASS_INFO_VALUE;
		end else if (pos == diag_record_pkg::POS_CHANNEL_KIND) begin
			value = diag_record_pkg::CHANNEL_KIND_VALUE;
		end else if (pos >= diag_record_pkg::POS_TIMESTAMP) begin
			value = stamp[8*(pos - diag_record_pkg::POS_TIMESTAMP) +: 8];
		end
		return value;
	endfunction

	// Two-stage synchroniser for the fault pins
	always_ff @(posedge mclk_in) begin
		if (!reset_n_in) begin
			fault_meta_q <= '0;
			fault_sync_q <= '0;
		end else begin
			fault_meta_q <= {overload_in, external_error_in, internal_error_in, module_failure_in};
			fault_sync_q <= fault_meta_q;
		end
	end

	// Access decode
	always_comb begin
		logic [4:0] limit;
		limit = record_limit(req_path_in, req_index_in, req_write_in);
		hit_kind = HIT_NONE;
		hit_pos = 5'd0;
		if (is_param(req_path_in, req_index_in, req_sub_in, req_byte_in, req_write_in)) begin
			hit_kind = HIT_PARAM;
		end else if (limit != 5'd0) begin
			if (req_byte_in < limit) begin
				hit_kind = HIT_RECORD;
				hit_pos = req_byte_in;
			end
		end else if (req_path_in == 2'(diag_record_pkg::PATH_SUBINDEX) && !req_write_in &&
				req_index_in == diag_record_pkg::SX_DIAG_INDEX) begin
			if (req_sub_in >= diag_record_pkg::SX_FIRST_BYTE &&
					req_sub_in <= diag_record_pkg::SX_LAST_BYTE &&
					req_byte_in == 5'd0) begin
				hit_kind = HIT_RECORD;
				hit_pos = 5'(req_sub_in - diag_record_pkg::SX_FIRST_BYTE);
			end else if (req_sub_in == diag_record_pkg::SX_TIMESTAMP &&
					req_byte_in < 5'(diag_record_pkg::TIMESTAMP_BYTES)) begin
				hit_kind = HIT_RECORD;
				hit_pos = diag_record_pkg::POS_TIMESTAMP + req_byte_in;
			end
		end
	end

	assign param_write = req_valid_in && req_write_in && hit_kind == HIT_PARAM;

	// Parameter byte; the host only writes it in stop state
	always_ff @(posedge mclk_in) begin
		if (!reset_n_in) begin
			diag_interrupt_enable_q <= diag_record_pkg::DIAG_INT_ENABLE_RESET;
		end else if (param_write && param_value_ok(req_wdata_in)) begin
			diag_interrupt_enable_q <= req_wdata_in;
		end
	end

	// Invalid parameter value flags a parameter error until a valid write
	always_ff @(posedge mclk_in) begin
		if (!reset_n_in) begin
			param_bad_q <= 1'b0;
		end else if (param_write) begin
			param_bad_q <= !param_value_ok(req_wdata_in);
		end
	end

	assign enabled = diag_interrupt_enable_q == diag_record_pkg::DIAG_INT_ENABLE;

	// Live error summary follows its causes
	always_comb begin
		error_summary_d = diag_record_pkg::ERROR_SUMMARY_RESET;
		error_summary_d[diag_record_pkg::ERR_MODULE_FAILURE] = fault_sync_q[0];
		error_summary_d[diag_record_pkg::ERR_INTERNAL] = fault_sync_q[1];
		error_summary_d[diag_record_pkg::ERR_EXTERNAL] = fault_sync_q[2];
		error_summary_d[diag_record_pkg::ERR_OVERLOAD] = |fault_sync_q[FAULT_W-1:3];
		error_summary_d[diag_record_pkg::ERR_PARAMETER] = param_bad_q;
	end

	// Registered so summary and interrupts move together
	always_ff @(posedge mclk_in) begin
		if (!reset_n_in) begin
			error_summary_q <= diag_record_pkg::ERROR_SUMMARY_RESET;
		end else begin
			error_summary_q <= error_summary_d;
		end
	end

	assign cause_any = |error_summary_q;
	// Shared by the pulse and timestamp logic
	assign raise_now = state_q == DIAG_QUIET && enabled && cause_any;
	assign fall_now = state_q == DIAG_RAISED && !cause_any;

	// Incoming and going diagnostic interrupt sequencing
	always_ff @(posedge mclk_in) begin
		if (!reset_n_in) begin
			state_q <= DIAG_QUIET;
		end else begin
			case (state_q)
				DIAG_QUIET: begin
					if (enabled && cause_any) begin
						state_q <= DIAG_RAISED;
					end
				end
				DIAG_RAISED: begin
					if (!cause_any) begin
						state_q <= DIAG_QUIET;
					end
				end
				default: begin
					state_q <= DIAG_QUIET;
				end
			endcase
		end
	end

	// Enabling with a cause present raises at once
	always_ff @(posedge mclk_in) begin
		if (!reset_n_in) begin
			diag_incoming_out <= 1'b0;
		end else begin
			diag_incoming_out <= raise_now;
		end
	end

	// Going follows once raised, even if disabled since
	always_ff @(posedge mclk_in) begin
		if (!reset_n_in) begin
			diag_going_out <= 1'b0;
		end else begin
			diag_going_out <= fall_now;
		end
	end

	// Timestamp of the incoming diagnostic
	always_ff @(posedge mclk_in) begin
		if (!reset_n_in) begin
			event_timestamp_q <= diag_record_pkg::TICKER_RESET;
		end else if (raise_now) begin
			event_timestamp_q <= usec_now;
		end
	end

	// Status straight from the enable byte
	always_ff @(posedge mclk_in) begin
		if (!reset_n_in) begin
			diag_enabled_out <= 1'b0;
		end else begin
			diag_enabled_out <= enabled;
		end
	end

	// Pending from incoming until going
	always_ff @(posedge mclk_in) begin
		if (!reset_n_in) begin
			diag_active_out <= 1'b0;
		end else begin
			diag_active_out <= state_q == DIAG_RAISED;
		end
	end

	// Registered answer one cycle after each request
	always_ff @(posedge mclk_in) begin
		if (!reset_n_in) begin
			rsp_valid_out <= 1'b0;
		end else begin
			rsp_valid_out <= req_valid_in;
		end
	end

	// Unmapped access answers with error and zero data
	always_ff @(posedge mclk_in) begin
		if (!reset_n_in) begin
			rsp_error_out <= 1'b0;
		end else begin
			rsp_error_out <= req_valid_in && hit_kind == HIT_NONE;
		end
	end

	// Read data only for mapped reads, zero otherwise
	always_ff @(posedge mclk_in) begin
		if (!reset_n_in) begin
			rsp_data_out <= 8'h00;
		end else if (!req_valid_in || req_write_in || hit_kind == HIT_NONE) begin
			rsp_data_out <= 8'h00;
		end else if (hit_kind == HIT_PARAM) begin
			rsp_data_out <= diag_interrupt_enable_q;
		end else begin
			rsp_data_out <= record_byte(hit_pos, error_summary_q, event_timestamp_q);
		end
	end

endmodule // output_module_diag_record

/* diag_host_model.sv */
`timescale 1ns/100ps
module diag_host_model (
	input wire logic mclk_in,
	input wire logic rsp_valid_in,
	input wire logic rsp_error_in,
	input wire logic [7:0] rsp_data_in,
	output logic req_valid_out,
	output logic req_write_out,
	output logic [1:0] req_path_out,
	output logic [15:0] req_index_out,
	output logic [7:0] req_sub_out,
	output logic [4:0] req_byte_out,
	output logic [7:0] req_wdata_out
);
	initial begin
		req_valid_out = 1'b0;
		{req_write_out, req_path_out, req_index_out, req_sub_out, req_byte_out, req_wdata_out} = '0;
	end
	// Writes of the enable byte only happen while the bench keeps the system stopped
	task automatic access(input logic w, input logic [1:0] p, input logic [15:0] ix,
		input logic [7:0] sx, input logic [4:0] b, input logic [7:0] wd,
		output logic [7:0] d, output logic e, output bit ok);
		@(negedge mclk_in);
		req_valid_out = 1'b1;
		{req_write_out, req_path_out, req_index_out, req_sub_out, req_byte_out, req_wdata_out} =
			{w, p, ix, sx, b, wd};
		@(negedge mclk_in);
		req_valid_out = 1'b0;
		// Released qualifiers no longer hold the last value
		{req_write_out, req_path_out, req_index_out, req_sub_out, req_byte_out, req_wdata_out} =
			~{w, p, ix, sx, b, wd};
		ok = rsp_valid_in === 1'b1;
		d = rsp_data_in;
		e = rsp_error_in;
	endtask
endmodule // diag_host_model

/* output_module_diag_record_monitor.sv */
`timescale 1ns/100ps
module output_module_diag_record_monitor (
	input wire logic mclk_in,
	input wire logic reset_n_in,
	input wire logic module_failure_in,
	input wire logic internal_error_in,
	input wire logic external_error_in,
	input wire logic [diag_record_pkg::OUTPUT_CHANNELS-1:0] overload_in,
	input wire logic req_valid_in,
	input wire logic req_write_in,
	input wire logic [1:0] req_path_in,
	input wire logic [15:0] req_index_in,
	input wire logic [7:0] req_sub_in,
	input wire logic [4:0] req_byte_in,
	input wire logic [7:0] req_wdata_in,
	input wire logic rsp_valid_out,
	input wire logic rsp_error_out,
	input wire logic [7:0] rsp_data_out,
	input wire logic diag_enabled_out,
	input wire logic diag_incoming_out,
	input wire logic diag_going_out,
	input wire logic diag_active_out
);
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!reset_n_in);
	wire logic quiet = !internal_error_in && !external_error_in && overload_in == 16'h0000;
	wire logic pwr = req_valid_in && req_write_in && req_byte_in == 5'h00 &&
		((req_path_in == 2'h0 && req_index_in == 16'h0000) ||
		(req_path_in == 2'h1 && req_index_in == 16'h3100) ||
		(req_path_in == 2'h2 && req_index_in == 16'h3100 && req_sub_in == 8'h01));
	property p_answer; req_valid_in |=> rsp_valid_out; endproperty
	a_answer: assert property (p_answer) else $error("request not answered");
	property p_idle; !req_valid_in |=> !rsp_valid_out && !rsp_error_out && rsp_data_out == 8'h00;
	endproperty
	a_idle: assert property (p_idle) else $error("answer without request");
	property p_bad_path; req_valid_in && req_path_in == 2'h3 |=> rsp_error_out; endproperty
	a_bad_path: assert property (p_bad_path) else $error("unused path accepted");
	property p_enable; pwr && req_wdata_in == 8'h40 |=> ##1 diag_enabled_out; endproperty
	a_enable: assert property (p_enable) else $error("enable byte not applied");
	property p_disable; pwr && req_wdata_in == 8'h00 |=> ##1 !diag_enabled_out; endproperty
	a_disable: assert property (p_disable) else $error("disable byte not applied");
	property p_in_pulse;
		diag_incoming_out |-> !diag_active_out ##1 !diag_incoming_out && diag_active_out;
	endproperty
	a_in_pulse: assert property (p_in_pulse) else $error("incoming pulse malformed");
	property p_go_pulse;
		diag_going_out |-> diag_active_out ##1 !diag_going_out && !diag_active_out;
	endproperty
	a_go_pulse: assert property (p_go_pulse) else $error("going pulse malformed");
	property p_in_enabled; diag_incoming_out |-> diag_enabled_out; endproperty
	a_in_enabled: assert property (p_in_enabled) else $error("incoming while disabled");
	property p_raise; diag_enabled_out && !diag_active_out && quiet && $rose(module_failure_in)
		|-> ##[2:6] diag_incoming_out; endproperty
	a_raise: assert property (p_raise) else $error("failure raised no interrupt");
	property p_fall;
		diag_active_out && quiet && $fell(module_failure_in) |-> ##[2:6] diag_going_out;
	endproperty
	a_fall: assert property (p_fall) else $error("cleared failure gave no going");
	c_in: cover property (diag_incoming_out);
	c_go: cover property (diag_going_out);
	c_err: cover property (rsp_error_out);
endmodule // output_module_diag_record_monitor
bind output_module_diag_record
	output_module_diag_record_monitor output_module_diag_record_monitor_i (.*);

/* output_module_diag_record_bench.sv */
`timescale 1ns/100ps
module output_module_diag_record_bench;
	logic mclk_in = 1'b0;
	logic reset_n_in = 1'b0;
	logic module_failure_in = 1'b0;
	logic internal_error_in = 1'b0;
	logic external_error_in = 1'b0;
	logic [15:0] overload_in = 16'h0000;
	logic req_valid_in, req_write_in, rsp_valid_out, rsp_error_out;
	logic [1:0] req_path_in;
	logic [15:0] req_index_in;
	logic [7:0] req_sub_in, req_wdata_in, rsp_data_out, v;
	logic [4:0] req_byte_in;
	logic diag_enabled_out, diag_incoming_out, diag_going_out, diag_active_out;
	int fails = 0, compares = 0, cyc = 0, sum = 0, ts = 0, at;
	output_module_diag_record output_module_diag_record_i (.*);
	diag_host_model diag_host_model_i (.mclk_in(mclk_in), .rsp_valid_in(rsp_valid_out),
		.rsp_error_in(rsp_error_out), .rsp_data_in(rsp_data_out), .req_valid_out(req_valid_in),
		.req_write_out(req_write_in), .req_path_out(req_path_in), .req_index_out(req_index_in),
		.req_sub_out(req_sub_in), .req_byte_out(req_byte_in), .req_wdata_out(req_wdata_in));
	initial forever #50 mclk_in = ~mclk_in;
	always @(posedge mclk_in) cyc <= reset_n_in ? cyc + 1 : 0;
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", compares, fails);
		if (fails == 0 && compares > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Expected is {error, data}
	task automatic xfer(input logic [1:0] p, input logic [15:0] ix, input logic [7:0] sx,
		input logic [4:0] b, input logic w, input logic [7:0] wd, input logic [8:0] exp);
		logic [7:0] d;
		logic e;
		bit ok;
		diag_host_model_i.access(w, p, ix, sx, b, wd, d, e, ok);
		check({ok, e, d}, {1'b1, exp});
	endtask
	function automatic logic [8:0] rec(input int b);
		case (b)
			0: return 9'(sum);
			1: return 9'h01F;
			4: return 9'h072;
			16, 17, 18, 19: return 9'((ts >> (8 * (b - 16))) & 255);
			default: return 9'h000;
		endcase
	endfunction
	task automatic dump();
		logic [8:0] exp_q[$];
		for (int b = 0; b < 20; b++) exp_q.push_back(rec(b));
		for (int b = 0; b < 20; b++) begin
			xfer(2'h0, 16'h0001, 8'h00, 5'(b), 1'b0, 8'h00, exp_q[b]);
			xfer(2'h1, 16'h2F01, 8'h00, 5'(b), 1'b0, 8'h00, exp_q[b]);
			if (b < 16) xfer(2'h2, 16'h5005, 8'(b + 2), 5'h00, 1'b0, 8'h00, exp_q[b]);
			else xfer(2'h2, 16'h5005, 8'h13, 5'(b - 16), 1'b0, 8'h00, exp_q[b]);
		end
	endtask
	task automatic cause(input int k, input logic s);
		@(negedge mclk_in);
		case (k)
			0: module_failure_in = s;
			1: internal_error_in = s;
			2: external_error_in = s;
			default: overload_in = s ? 16'h0001 << ($urandom % 16) : 16'h0000;
		endcase
	endtask
	task automatic pulse(input bit going);
		at = -1;
		for (int i = 0; i < 12 && at < 0; i++) begin
			@(negedge mclk_in);
			if ((going ? diag_going_out : diag_incoming_out) === 1'b1) at = cyc;
		end
		check(32'(at >= 0), 32'h1);
		if (at < 0) give_verdict();
	endtask
	initial begin
		void'($urandom(79));
		repeat (8) @(negedge mclk_in);
		reset_n_in = 1'b1;
		dump();
		for (int b = 0; b < 5; b++) begin
			xfer(2'h0, 16'h0000, 8'h00, 5'(b), 1'b0, 8'h00, b < 4 ? rec(b) : 9'h100);
			xfer(2'h1, 16'h2F00, 8'h00, 5'(b), 1'b0, 8'h00, b < 4 ? rec(b) : 9'h100);
		end
		xfer(2'h2, 16'h5005, 8'h12, 5'h00, 1'b0, 8'h00, 9'h100);
		xfer(2'h3, 16'h0001, 8'h00, 5'h00, 1'b0, 8'h00, 9'h100);
		$display("test record_paths done");
		v = 8'($urandom);
		if (v == 8'h00 || v == 8'h40) v = 8'h55;
		xfer(2'h1, 16'h3100, 8'h00, 5'h00, 1'b1, v, 9'h000);
		repeat (2) @(negedge mclk_in);
		sum = 8'h80;
		xfer(2'h0, 16'h0000, 8'h00, 5'h00, 1'b0, 8'h00, rec(0));
		xfer(2'h0, 16'h0000, 8'h00, 5'h00, 1'b1, 8'h40, 9'h000);
		repeat (2) @(negedge mclk_in);
		check(32'(diag_enabled_out), 32'h1);
		sum = 0;
		xfer(2'h1, 16'h3100, 8'h00, 5'h00, 1'b0, 8'h00, 9'h040);
		xfer(2'h0, 16'h0000, 8'h00, 5'h00, 1'b0, 8'h00, rec(0));
		$display("test parameter done");
		for (int k = 0; k < 4; k++) begin
			cause(k, 1'b1);
			pulse(1'b0);
			sum = k == 3 ? 8'h10 : 8'h01 << k;
			ts = (at - 1) / 10;
			dump();
			cause(k, 1'b0);
			pulse(1'b1);
			sum = 0;
			xfer(2'h0, 16'h0000, 8'h00, 5'h00, 1'b0, 8'h00, rec(0));
		end
		$display("test fault_events done");
		xfer(2'h2, 16'h3100, 8'h01, 5'h00, 1'b1, 8'h00, 9'h000);
		xfer(2'h2, 16'h3100, 8'h01, 5'h00, 1'b0, 8'h00, 9'h000);
		check(32'(diag_enabled_out), 32'h0);
		cause(0, 1'b1);
		repeat (8) @(negedge mclk_in);
		check(32'(diag_active_out), 32'h0);
		sum = 1;
		xfer(2'h0, 16'h0000, 8'h00, 5'h00, 1'b0, 8'h00, rec(0));
		cause(0, 1'b0);
		$display("test disabled done");
		give_verdict();
	end
endmodule // output_module_diag_record_bench
